// ---- aoi_defines.svh ----
// Constants for the OR, increment, shift and move datapath
`ifndef AOI_DEFINES_SVH
`define AOI_DEFINES_SVH
`define AOI_DATA_W     8
`define AOI_ADDR_W     7
`define AOI_ACC_RESET  8'h00
`define AOI_ZERO_RESET 1'h0
`define AOI_CARRY_RESET 1'h0
`define AOI_WADDR_RESET 7'h00
`define AOI_WDATA_RESET 8'h00
`define AOI_MSB        7
`define AOI_LSB        0
`define AOI_DEST_ACC   1'h0
`define AOI_DEST_FILE  1'h1
`endif

// ---- aoi_pkg.sv ----
// Types shared by the datapath files
package aoi_pkg;
	typedef enum logic [2:0] {
		AOI_OP_NONE      = 3'h0,
		AOI_OP_OR_LIT    = 3'h1,
		AOI_OP_INC_FILE  = 3'h2,
		AOI_OP_OR_FILE   = 3'h3,
		AOI_OP_SHL_FILE  = 3'h4,
		AOI_OP_SHR_FILE  = 3'h5,
		AOI_OP_COPY_FILE = 3'h6
	} aoi_op_type;

	typedef struct packed {
		aoi_op_type op;
		logic       dest;
		logic [6:0] addr;
		logic [7:0] literal;
	} aoi_cmd_type;

	typedef struct packed {
		logic [7:0] value;
		logic       carry_out;
		logic       carry_upd;
		logic       zero_upd;
	} aoi_res_type;
endpackage : aoi_pkg

// ---- aoi_alu.sv ----
// Combinational result and flag-update selection per operation
`timescale 1ns/10ps
`include "aoi_defines.svh"
module aoi_alu
	import aoi_pkg::*;
(
	// Operation and operands
	input  wire aoi_op_type  op,
	input  wire logic [7:0]  acc,
	input  wire logic [7:0]  file_data,
	input  wire logic [7:0]  literal,
	// Result
	output aoi_res_type      res
);
	// One case per operation; unused ops update nothing
	always_comb begin
		res = '0;
		case (op)
			AOI_OP_OR_LIT: begin
				res.value    = acc | literal;
				res.zero_upd = 1'b1;
			end
			AOI_OP_INC_FILE: begin
				res.value    = file_data + 8'h01;
				res.zero_upd = 1'b1;
			end
			AOI_OP_OR_FILE: begin
				res.value    = acc | file_data;
				res.zero_upd = 1'b1;
			end
			AOI_OP_SHL_FILE: begin
				res.value     = {file_data[`AOI_MSB-1:0], 1'b0};
				res.carry_out = file_data[`AOI_MSB];
				res.carry_upd = 1'b1;
				res.zero_upd  = 1'b1;
			end
			AOI_OP_SHR_FILE: begin
				res.value     = {1'b0, file_data[`AOI_MSB:1]};
				res.carry_out = file_data[`AOI_LSB];
				res.carry_upd = 1'b1;
				res.zero_upd  = 1'b1;
			end
			AOI_OP_COPY_FILE: begin
				res.value    = file_data;
				res.zero_upd = 1'b1;
			end
			default: begin
				res = '0;
			end
		endcase
	end
endmodule : aoi_alu

// ---- aoi_datapath.sv ----
// Top of the OR, increment, shift and move datapath with acc and flags
`timescale 1ns/10ps
`include "aoi_defines.svh"
//Contract
// - OR literal into acc, zero flag only
// - Increment file, dest bit picks target
// - OR acc with file, dest picks target
// - Left shift: bit7 to carry, flags updated
// - Left shift fills bit0 with zero
// - Copy file to acc or itself, one cycle
// - Copy updates zero flag even on rewrite
// - Right shift: bit0 to carry, bit7 zero
module aoi_datapath
	import aoi_pkg::*;
(
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RESET_N,
	// Decoded instruction, one per cycle
	input  wire logic        CMD_VALID,
	input  wire aoi_cmd_type CMD,
	// File register read port (same clock)
	output logic [6:0]       FILE_RADDR,
	input  wire logic [7:0]  FILE_RDATA,
	// File register write port
	output logic             FILE_WE,
	output logic [6:0]       FILE_WADDR,
	output logic [7:0]       FILE_WDATA,
	// Architectural state
	output logic [7:0]       ACC,
	output logic             ZERO_FLAG,
	output logic             CARRY_FLAG
);
	// Two-stage release of the asynchronous reset
	logic [1:0]  reset_sync;
	logic        rst_n;

	// Result bundle from the operation unit
	aoi_res_type res;

	// Decoded control for the instruction in flight
	logic        op_known;
	logic        exec;
	logic        to_file;
	logic        to_acc;
	logic        write_zero;
	logic        write_carry;
	logic        result_zero;

	// Operation codes handled here:
	//   Or literal  - acc or literal into acc, zero flag
	//   Increment   - file plus one, zero flag
	//   Or file     - acc or file, zero flag
	//   Shift left  - msb out to carry, zero in at lsb
	//   Shift right - lsb out to carry, zero in at msb
	//   Copy        - file unchanged, zero flag even on rewrite

	// True only for the six implemented operation codes
	function automatic logic op_is_known(aoi_op_type op);
		logic known;
		known = 1'b0;
		case (op)
			AOI_OP_OR_LIT: begin
				known = 1'b1;
			end
			AOI_OP_INC_FILE: begin
				known = 1'b1;
			end
			AOI_OP_OR_FILE: begin
				known = 1'b1;
			end
			AOI_OP_SHL_FILE: begin
				known = 1'b1;
			end
			AOI_OP_SHR_FILE: begin
				known = 1'b1;
			end
			AOI_OP_COPY_FILE: begin
				known = 1'b1;
			end
			default: begin
				known = 1'b0; // Idle code and spare code
			end
		endcase
		return known;
	endfunction : op_is_known

	// Operations whose dest bit may send the result back to the file
	function automatic logic op_has_file_dest(aoi_op_type op);
		logic has_dest;
		has_dest = 1'b0;
		case (op)
			AOI_OP_INC_FILE: begin
				has_dest = 1'b1;
			end
			AOI_OP_OR_FILE: begin
				has_dest = 1'b1;
			end
			AOI_OP_SHL_FILE: begin
				has_dest = 1'b1;
			end
			AOI_OP_SHR_FILE: begin
				has_dest = 1'b1;
			end
			AOI_OP_COPY_FILE: begin
				has_dest = 1'b1;
			end
			default: begin
				has_dest = 1'b0; // Literal OR has no file operand
			end
		endcase
		return has_dest;
	endfunction : op_has_file_dest

	// Zero test over the whole byte, never a slice of it
	function automatic logic is_zero_byte(logic [7:0] value);
		return (value == 8'h00);
	endfunction : is_zero_byte

	// Reset release through two flops; assert is async
	// Every state flop below resets from the synchronised copy, so all of
	// them leave reset on the same edge and a slow release on the pin
	// cannot let half the state start a cycle early
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			reset_sync <= 2'h0;
		end else begin
			reset_sync <= {reset_sync[0], 1'b1};
		end
	end
	assign rst_n = reset_sync[1];

	// File read is combinational so each op takes a single cycle
	assign FILE_RADDR  = CMD.addr;

	// Spare and idle codes are dropped whole, leaving all state alone
	assign op_known    = op_is_known(CMD.op);
	assign exec        = CMD_VALID && op_known;

	// Literal OR always targets the accumulator,
	// whatever its dest bit says
	assign to_file     = (CMD.dest == `AOI_DEST_FILE) && op_has_file_dest(CMD.op);
	assign to_acc      = !to_file;

	// Flag enables follow the operation unit, so decode lives in one place
	assign write_zero  = exec && res.zero_upd;
	assign write_carry = exec && res.carry_upd;
	assign result_zero = is_zero_byte(res.value);

	// Timing of one instruction:
	//   Operands settle from CMD, ACC and the file read port
	//   The taking edge loads ACC, the zero flag and the carry
	//   A file write-back leaves as a one-cycle strobe after that edge
	//   Address and data of the last write then hold until the next one
	// Limitation: a read of the byte written by the previous instruction
	//   sees the old contents unless the file forwards its pending write;
	//   this unit keeps no copy, to stay free of a second data path

	aoi_alu u_alu (
		.op        (CMD.op),
		.acc       (ACC),
		.file_data (FILE_RDATA),
		.literal   (CMD.literal),
		.res       (res)
	);

	// Accumulator destination
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ACC <= `AOI_ACC_RESET;
		end else if (exec && to_acc) begin
			ACC <= res.value;
		end
	end

	// Write strobe lasts exactly one cycle per write-back
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			FILE_WE <= 1'b0;
		end else begin
			FILE_WE <= exec && to_file;
		end
	end

	// Write address holds between writes so the file may sample late
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			FILE_WADDR <= `AOI_WADDR_RESET;
		end else if (exec && to_file) begin
			FILE_WADDR <= CMD.addr;
		end
	end

	// Write data from a flop, never straight from the operation unit
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			FILE_WDATA <= `AOI_WDATA_RESET;
		end else if (exec && to_file) begin
			FILE_WDATA <= res.value;
		end
	end

	// Zero flag from full 8-bit result
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ZERO_FLAG <= `AOI_ZERO_RESET;
		end else if (write_zero) begin
			ZERO_FLAG <= result_zero;
		end
	end

	// Shift-out bit, touched only by shifts
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			CARRY_FLAG <= `AOI_CARRY_RESET;
		end else if (write_carry) begin
			CARRY_FLAG <= res.carry_out;
		end
	end
endmodule : aoi_datapath

// ---- aoi_assertions.sv ----
// Port checker for the datapath
`timescale 1ns/10ps
module aoi_assertions import aoi_pkg::*; (
	input wire logic SYS_CLK,RESET_N,CMD_VALID,FILE_WE,ZERO_FLAG,CARRY_FLAG,
	input wire aoi_cmd_type CMD,
	input wire logic [6:0] FILE_RADDR,FILE_WADDR,
	input wire logic [7:0] FILE_RDATA,FILE_WDATA,ACC
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	// Taken opcode, none when idle
	wire [2:0] o=CMD_VALID?CMD.op:3'h0;
	wire d=CMD.dest;
	logic [7:0] pf,pa;
	// Operands as seen at the taking edge
	always_ff @(posedge SYS_CLK) begin
		pf<=FILE_RDATA;
		pa<=ACC;
	end
	property p_orl; o==1|=>ACC==(pa|$past(CMD.literal))&&!FILE_WE; endproperty
	a_orl: assert property(p_orl) else $error("orl");
	property p_inc; o==2&&d|=>FILE_WE&&FILE_WDATA==pf+8'h01; endproperty
	a_inc: assert property(p_inc) else $error("inc");
	property p_orf; o==3&&!d|=>ACC==(pa|pf)&&!FILE_WE; endproperty
	a_orf: assert property(p_orf) else $error("orf");
	property p_shl; o==4&&!d|=>{CARRY_FLAG,ACC}=={pf,1'b0}; endproperty
	a_shl: assert property(p_shl) else $error("shl");
	property p_shr; o==5&&d|=>{FILE_WDATA,CARRY_FLAG}=={1'b0,pf}; endproperty
	a_shr: assert property(p_shr) else $error("shr");
	property p_cpy; o==6&&d|=>FILE_WE&&FILE_WADDR==$past(CMD.addr)&&FILE_WDATA==pf; endproperty
	a_cpy: assert property(p_cpy) else $error("cpy");
	property p_cpz; o==6|=>ZERO_FLAG==(pf==8'h00); endproperty
	a_cpz: assert property(p_cpz) else $error("cpz");
	property p_z; FILE_WE|->ZERO_FLAG==(FILE_WDATA==8'h00); endproperty
	a_z: assert property(p_z) else $error("z");
	cover property(o==5);
	cover property(o==4);
	cover property(FILE_WE&&ZERO_FLAG);
endmodule : aoi_assertions

// ---- aoi_file_model.sv ----
// File register model with same-cycle read
`timescale 1ns/10ps
module aoi_file_model (
	input wire logic SYS_CLK,FILE_WE,
	input wire logic [6:0] FILE_RADDR,FILE_WADDR,
	input wire logic [7:0] FILE_WDATA,
	output logic [7:0] FILE_RDATA
);
	logic [7:0] mem[128];
	initial for(int i=0;i<128;i++) mem[i]=8'(i)^8'hA5;
	always @(posedge SYS_CLK) if(FILE_WE) mem[FILE_WADDR]<=FILE_WDATA;
	// Forward a write still in flight, it lands one edge late
	assign FILE_RDATA=(FILE_WE&&FILE_WADDR==FILE_RADDR)?FILE_WDATA:mem[FILE_RADDR];
endmodule : aoi_file_model

// ---- tb_aoi_datapath.sv ----
// Self-checking datapath bench
`timescale 1ns/10ps
`define CHK(e,s) begin \
	checks++; \
	if((s)!==(e)) begin \
		failures++; \
		$display("CHECK FAILED state exp %h got %h",e,s); \
	end \
end
module tb_aoi_datapath import aoi_pkg::*;;
	logic SYS_CLK=0,RESET_N=0,CMD_VALID=0,FILE_WE,ZERO_FLAG,CARRY_FLAG,z=0,c=0,we;
	aoi_cmd_type CMD='0;
	logic [6:0] FILE_RADDR,FILE_WADDR,wa=0;
	logic [7:0] FILE_RDATA,FILE_WDATA,ACC,acc=0,wd=0,r,f,mem[128];
	logic [25:0] q[$],e,seen;
	logic [31:0] s=32'h6B03;
	int checks=0,failures=0;
	aoi_datapath u_aoi_datapath(.*);
	aoi_file_model u_aoi_file_model(.*);
	// Everything the block leaves behind, write address included
	assign seen={ACC,ZERO_FLAG,CARRY_FLAG,FILE_WE,FILE_WADDR,FILE_WDATA};
	initial forever #10 SYS_CLK=~SYS_CLK;
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0],v[31]^v[21]^v[1]^v[0]};
	endfunction : lfsr
	// Drive one command and note what it must leave behind
	task automatic run(logic [2:0] o,logic d,logic [6:0] a,logic [7:0] l);
		@(negedge SYS_CLK);
		CMD_VALID=1;
		CMD={o,d,a,l};
		f=mem[a];
		case(o)
		1: r=acc|l;
		2: r=f+8'h01;
		3: r=acc|f;
		4: {c,r}={f,1'b0};
		5: {r,c}={1'b0,f};
		6: r=f;
		default: r=acc;
		endcase
		we=d&&o>1&&o<7;
		// Idle and spare codes leave the flags alone
		if(o!=0&&o!=7) z=r==0;
		if(we) {mem[a],wa,wd}={r,a,r};
		else acc=r;
		q.push_back({acc,z,c,we,wa,wd});
	endtask : run
	// Results settle just after the taking edge
	always @(posedge SYS_CLK) if(CMD_VALID) begin
		#1 e=q.pop_front();
		`CHK(e,seen)
	end
	task automatic results;
		$display("checks %0d failures %0d",checks,failures);
		if(failures==0&&checks>0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	initial begin
		for(int i=0;i<128;i++) mem[i]=8'(i)^8'hA5;
		repeat(4) @(negedge SYS_CLK);
		RESET_N=1;
		repeat(2) @(negedge SYS_CLK);
		// Wrap to zero, rewrite copy, ignored opcode, spare code on a live acc
		run(2,1,7'h5A,0);
		run(6,1,7'h5A,0);
		run(0,0,7'h5A,8'hFF);
		run(1,0,7'h00,8'h3C);
		run(7,0,7'h5A,8'hFF);
		run(7,1,7'h11,8'h00);
		repeat(400) begin
			s=lfsr(s);
			run(s[2:0]==7?3'h6:s[2:0],s[3],s[10:4],s[18:11]);
		end
		@(negedge SYS_CLK) CMD_VALID=0;
		repeat(2) @(negedge SYS_CLK);
		results();
	end
endmodule : tb_aoi_datapath
bind aoi_datapath aoi_assertions u_aoi_assertions(.*);
